// ### bank3_sfr_pkg.sv
package bank3_sfr_pkg;

  localparam logic [8:0] ADDR_INDIRECT   = 9'h180;
  localparam logic [8:0] ADDR_OPTION     = 9'h181;
  localparam logic [8:0] ADDR_PCL        = 9'h182;
  localparam logic [8:0] ADDR_STATUS     = 9'h183;
  localparam logic [8:0] ADDR_POINTER    = 9'h184;
  localparam logic [8:0] ADDR_DIR_B      = 9'h186;
  localparam logic [8:0] ADDR_DIR_F      = 9'h187;
  localparam logic [8:0] ADDR_DIR_G      = 9'h188;
  localparam logic [8:0] ADDR_PROGRAM_COUNTER_HIGH_LATCH     = 9'h18a;
  localparam logic [8:0] ADDR_INTCTL     = 9'h18b;
  localparam logic [8:0] ADDR_PM_DATA_LO = 9'h18c;
  localparam logic [8:0] ADDR_PM_ADDR_LO = 9'h18d;
  localparam logic [8:0] ADDR_PM_DATA_HI = 9'h18e;
  localparam logic [8:0] ADDR_PM_ADDR_HI = 9'h18f;

  localparam logic [7:0] RST_OPTION  = 8'hff;
  localparam logic [7:0] RST_PCL     = 8'h00;
  localparam logic [7:0] RST_DIR     = 8'hff;
  localparam logic [7:0] RST_PROGRAM_COUNTER_HIGH_LATCH  = 8'h00;
  localparam logic [7:0] RST_INTCTL  = 8'h00;
  localparam logic [7:0] RST_ZERO    = 8'h00;
  // Status at power-up: banks 0, both reset-cause flags set, arithmetic flags clear.
  localparam logic [7:0] RST_STATUS  = 8'h18;

  localparam logic [7:0] MASK_PROGRAM_COUNTER_HIGH_LATCH   = 8'h1f;
  localparam logic [7:0] MASK_PM_DATH  = 8'h3f;
  localparam logic [7:0] MASK_PM_ADRH  = 8'h1f;

  localparam int BIT_IRP = 7;
  localparam int BIT_RP1 = 6;
  localparam int BIT_RP0 = 5;
  localparam int BIT_TO  = 4;
  localparam int BIT_PD  = 3;
  localparam int BIT_Z   = 2;
  localparam int BIT_DC  = 1;
  localparam int BIT_C   = 0;

  typedef struct packed {
    logic       wr;
    logic       clr;
    logic [8:0] addr;
    logic [7:0] data;
  } core_wr_t;

  typedef struct packed {
    logic upd_z;
    logic upd_dc;
    logic upd_c;
    logic sub;
    logic z;
    logic dc;
    logic c;
  } alu_flags_t;

endpackage

// ### bank3_sfr_and_status_flags.sv
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - One status register holds arithmetic flags, reset-cause flags and bank select bits.
// - Any instruction may write the status register like any other location.
// - When an instruction updates zero, digit-carry or carry, the written data for them is ignored.
// - The time-out and power-down flags cannot be written by instructions.
// - Clearing the status register clears the three bank bits and sets zero, keeping the rest.
// - In subtraction carry and digit carry act as inverted borrow and inverted digit borrow.
// - Status bits 6 and 5 select the direct-addressing bank, 11 being the top bank.
// - Power-down is set at power-up or watchdog clear and cleared by sleep.
module bank3_sfr_and_status_flags (
  // Clock and reset
  input  wire logic                      mclk_in,
  input  wire logic                      rstn_in,
  // Core access
  input  wire bank3_sfr_pkg::core_wr_t   core_wr_in,
  input  wire logic [8:0]                rd_addr_in,
  output logic      [7:0]                rd_data_out,
  input  wire bank3_sfr_pkg::alu_flags_t alu_flags_in,
  // Reset-cause events from core
  input  wire logic                      watchdog_clear_instr_in,
  input  wire logic                      sleep_instr_in,
  input  wire logic                      watchdog_timeout_in,
  // Indirect data memory port
  output logic      [8:0]                indirect_addr_out,
  output logic                           indirect_wr_out,
  output logic      [7:0]                indirect_wdata_out,
  input  wire logic [7:0]                indirect_rdata_in,
  // Register contents
  output logic      [1:0]                direct_bank_out,
  output logic      [7:0]                status_flags_out,
  output logic      [7:0]                option_config_out,
  output logic      [7:0]                port_b_direction_out,
  output logic      [7:0]                port_f_direction_out,
  output logic      [7:0]                port_g_direction_out,
  output logic      [7:0]                interrupt_control_out,
  output logic      [7:0]                program_counter_low_out,
  output logic      [4:0]                program_counter_high_latch_out,
  output logic      [7:0]                progmem_data_low_out,
  output logic      [7:0]                progmem_address_low_out,
  output logic      [5:0]                progmem_data_high_out,
  output logic      [4:0]                progmem_address_high_out
);

  logic [7:0] option_reg;
  logic [7:0] pcl_reg;
  logic [7:0] status_reg;
  logic [7:0] status_next;
  logic [7:0] pointer_reg;
  logic [7:0] dir_b_reg;
  logic [7:0] dir_f_reg;
  logic [7:0] dir_g_reg;
  logic [7:0] program_counter_high_latch_reg;
  logic [7:0] intctl_reg;
  logic [7:0] pm_data_lo_reg;
  logic [7:0] pm_addr_lo_reg;
  logic [7:0] pm_data_hi_reg;
  logic [7:0] pm_addr_hi_reg;
  logic [7:0] wval;

  function automatic logic hit(input logic [8:0] a);
    hit = core_wr_in.wr && (core_wr_in.addr == a);
  endfunction

  // A clear writes zero through the same path as a move.
  assign wval = core_wr_in.clr ? bank3_sfr_pkg::RST_ZERO : core_wr_in.data;

  // Pointer plus the indirect bank bit forms the full nine-bit address.
  assign indirect_addr_out  = {status_reg[bank3_sfr_pkg::BIT_IRP], pointer_reg};
  // The decode function reads the write struct directly, and a continuous assignment would
  // not wake on it. The strobe is therefore built in a process that tracks what it reads.
  always_comb begin
    indirect_wr_out = hit(bank3_sfr_pkg::ADDR_INDIRECT);
  end
  assign indirect_wdata_out = wval;

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      option_reg     <= bank3_sfr_pkg::RST_OPTION;
      pcl_reg        <= bank3_sfr_pkg::RST_PCL;
      pointer_reg    <= bank3_sfr_pkg::RST_ZERO;
      dir_b_reg      <= bank3_sfr_pkg::RST_DIR;
      dir_f_reg      <= bank3_sfr_pkg::RST_DIR;
      dir_g_reg      <= bank3_sfr_pkg::RST_DIR;
      program_counter_high_latch_reg     <= bank3_sfr_pkg::RST_PROGRAM_COUNTER_HIGH_LATCH;
      intctl_reg     <= bank3_sfr_pkg::RST_INTCTL;
      pm_data_lo_reg <= bank3_sfr_pkg::RST_ZERO;
      pm_addr_lo_reg <= bank3_sfr_pkg::RST_ZERO;
      pm_data_hi_reg <= bank3_sfr_pkg::RST_ZERO;
      pm_addr_hi_reg <= bank3_sfr_pkg::RST_ZERO;
    end else begin
      if (hit(bank3_sfr_pkg::ADDR_OPTION)) begin
        option_reg <= wval;
      end
      if (hit(bank3_sfr_pkg::ADDR_PCL)) begin
        pcl_reg <= wval;
      end
      if (hit(bank3_sfr_pkg::ADDR_POINTER)) begin
        pointer_reg <= wval;
      end
      if (hit(bank3_sfr_pkg::ADDR_DIR_B)) begin
        dir_b_reg <= wval;
      end
      if (hit(bank3_sfr_pkg::ADDR_DIR_F)) begin
        dir_f_reg <= wval;
      end
      if (hit(bank3_sfr_pkg::ADDR_DIR_G)) begin
        dir_g_reg <= wval;
      end
      if (hit(bank3_sfr_pkg::ADDR_PROGRAM_COUNTER_HIGH_LATCH)) begin
        program_counter_high_latch_reg <= wval & bank3_sfr_pkg::MASK_PROGRAM_COUNTER_HIGH_LATCH;
      end
      if (hit(bank3_sfr_pkg::ADDR_INTCTL)) begin
        intctl_reg <= wval;
      end
      if (hit(bank3_sfr_pkg::ADDR_PM_DATA_LO)) begin
        pm_data_lo_reg <= wval;
      end
      if (hit(bank3_sfr_pkg::ADDR_PM_ADDR_LO)) begin
        pm_addr_lo_reg <= wval;
      end
      if (hit(bank3_sfr_pkg::ADDR_PM_DATA_HI)) begin
        pm_data_hi_reg <= wval & bank3_sfr_pkg::MASK_PM_DATH;
      end
      if (hit(bank3_sfr_pkg::ADDR_PM_ADDR_HI)) begin
        pm_addr_hi_reg <= wval & bank3_sfr_pkg::MASK_PM_ADRH;
      end
    end
  end

  // Flag results from the ALU override the written data, so a status write that
  // also updates flags may not give software the value it asked for.
  always_comb begin
    status_next = status_reg;
    if (hit(bank3_sfr_pkg::ADDR_STATUS)) begin
      status_next[bank3_sfr_pkg::BIT_IRP] = wval[bank3_sfr_pkg::BIT_IRP];
      status_next[bank3_sfr_pkg::BIT_RP1] = wval[bank3_sfr_pkg::BIT_RP1];
      status_next[bank3_sfr_pkg::BIT_RP0] = wval[bank3_sfr_pkg::BIT_RP0];
      // A clear sets zero by itself, so it holds even when the core sends no flag strobe.
      if (core_wr_in.clr) begin
        status_next[bank3_sfr_pkg::BIT_Z]  = 1'b1;
      end else begin
        status_next[bank3_sfr_pkg::BIT_Z]  = wval[bank3_sfr_pkg::BIT_Z];
        status_next[bank3_sfr_pkg::BIT_DC] = wval[bank3_sfr_pkg::BIT_DC];
        status_next[bank3_sfr_pkg::BIT_C]  = wval[bank3_sfr_pkg::BIT_C];
      end
    end
    // The ALU presents borrow flags already inverted during subtraction.
    if (alu_flags_in.upd_z) begin
      status_next[bank3_sfr_pkg::BIT_Z] = alu_flags_in.z;
    end
    if (alu_flags_in.upd_dc) begin
      status_next[bank3_sfr_pkg::BIT_DC] = alu_flags_in.dc;
    end
    if (alu_flags_in.upd_c) begin
      status_next[bank3_sfr_pkg::BIT_C] = alu_flags_in.c;
    end
    // Reset-cause flags follow only events, never data; the timeout event wins.
    if (sleep_instr_in) begin
      status_next[bank3_sfr_pkg::BIT_PD] = 1'b0;
      status_next[bank3_sfr_pkg::BIT_TO] = 1'b1;
    end
    if (watchdog_clear_instr_in) begin
      status_next[bank3_sfr_pkg::BIT_PD] = 1'b1;
      status_next[bank3_sfr_pkg::BIT_TO] = 1'b1;
    end
    if (watchdog_timeout_in) begin
      status_next[bank3_sfr_pkg::BIT_TO] = 1'b0;
    end
  end

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      status_reg <= bank3_sfr_pkg::RST_STATUS;
    end else begin
      status_reg <= status_next;
    end
  end

  always_comb begin
    unique case (rd_addr_in)
      bank3_sfr_pkg::ADDR_INDIRECT:   rd_data_out = indirect_rdata_in;
      bank3_sfr_pkg::ADDR_OPTION:     rd_data_out = option_reg;
      bank3_sfr_pkg::ADDR_PCL:        rd_data_out = pcl_reg;
      bank3_sfr_pkg::ADDR_STATUS:     rd_data_out = status_reg;
      bank3_sfr_pkg::ADDR_POINTER:    rd_data_out = pointer_reg;
      bank3_sfr_pkg::ADDR_DIR_B:      rd_data_out = dir_b_reg;
      bank3_sfr_pkg::ADDR_DIR_F:      rd_data_out = dir_f_reg;
      bank3_sfr_pkg::ADDR_DIR_G:      rd_data_out = dir_g_reg;
      bank3_sfr_pkg::ADDR_PROGRAM_COUNTER_HIGH_LATCH:     rd_data_out = program_counter_high_latch_reg;
      bank3_sfr_pkg::ADDR_INTCTL:     rd_data_out = intctl_reg;
      bank3_sfr_pkg::ADDR_PM_DATA_LO: rd_data_out = pm_data_lo_reg;
      bank3_sfr_pkg::ADDR_PM_ADDR_LO: rd_data_out = pm_addr_lo_reg;
      bank3_sfr_pkg::ADDR_PM_DATA_HI: rd_data_out = pm_data_hi_reg;
      bank3_sfr_pkg::ADDR_PM_ADDR_HI: rd_data_out = pm_addr_hi_reg;
      default:                        rd_data_out = bank3_sfr_pkg::RST_ZERO;
    endcase
  end

  assign direct_bank_out = {status_reg[bank3_sfr_pkg::BIT_RP1],
                            status_reg[bank3_sfr_pkg::BIT_RP0]};
  assign status_flags_out               = status_reg;
  assign option_config_out              = option_reg;
  assign port_b_direction_out           = dir_b_reg;
  assign port_f_direction_out           = dir_f_reg;
  assign port_g_direction_out           = dir_g_reg;
  assign interrupt_control_out          = intctl_reg;
  assign program_counter_low_out        = pcl_reg;
  assign program_counter_high_latch_out = program_counter_high_latch_reg[4:0];
  assign progmem_data_low_out           = pm_data_lo_reg;
  assign progmem_address_low_out        = pm_addr_lo_reg;
  assign progmem_data_high_out          = pm_data_hi_reg[5:0];
  assign progmem_address_high_out       = pm_addr_hi_reg[4:0];

endmodule

`default_nettype wire

// ### bank3_sfr_checker.sv
`timescale 1ns/1ps
`default_nettype none
module bank3_sfr_checker (
  // Clock and reset
  input wire logic                      mclk_in,
  input wire logic                      rstn_in,
  // Core side
  input wire bank3_sfr_pkg::core_wr_t   core_wr_in,
  input wire logic [8:0]                rd_addr_in,
  input wire logic [7:0]                rd_data_out,
  input wire bank3_sfr_pkg::alu_flags_t alu_flags_in,
  input wire logic                      watchdog_clear_instr_in,
  input wire logic                      sleep_instr_in,
  input wire logic                      watchdog_timeout_in,
  // Indirect port and status
  input wire logic [8:0]                indirect_addr_out,
  input wire logic                      indirect_wr_out,
  input wire logic [7:0]                indirect_rdata_in,
  input wire logic [1:0]                direct_bank_out,
  input wire logic [7:0]                status_flags_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rstn_in);
  property p_ind_wr;
    core_wr_in.wr && core_wr_in.addr == 9'h180 |-> indirect_wr_out;
  endproperty
  a_ind_wr: assert property (p_ind_wr) else $error("indirect write not forwarded");
  property p_ind_rd;
    rd_addr_in == 9'h180 |-> rd_data_out == indirect_rdata_in;
  endproperty
  a_ind_rd: assert property (p_ind_rd) else $error("indirect read not forwarded");
  property p_ptr;
    core_wr_in.wr && !core_wr_in.clr && core_wr_in.addr == 9'h184
      |=> indirect_addr_out[7:0] == $past(core_wr_in.data);
  endproperty
  a_ptr: assert property (p_ptr) else $error("pointer not driving address");
  property p_latch;
    rd_addr_in == 9'h18a |-> rd_data_out[7:5] == 3'h0;
  endproperty
  a_latch: assert property (p_latch) else $error("latch upper bits not zero");
  property p_ro;
    !watchdog_clear_instr_in && !sleep_instr_in && !watchdog_timeout_in
      |=> $stable(status_flags_out[4:3]);
  endproperty
  a_ro: assert property (p_ro) else $error("reset-cause flags changed");
  property p_alu;
    alu_flags_in.upd_c |=> status_flags_out[0] == $past(alu_flags_in.c);
  endproperty
  a_alu: assert property (p_alu) else $error("carry not from result");
  property p_clr;
    core_wr_in.wr && core_wr_in.clr && core_wr_in.addr == 9'h183
      |=> status_flags_out[7:5] == 3'h0 && (status_flags_out[2] || $past(alu_flags_in.upd_z));
  endproperty
  a_clr: assert property (p_clr) else $error("clear left bank bits");
  property p_bank;
    direct_bank_out == status_flags_out[6:5];
  endproperty
  a_bank: assert property (p_bank) else $error("bank select mismatch");
  property p_sleep;
    sleep_instr_in && !watchdog_clear_instr_in |=> !status_flags_out[3];
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep kept power-down flag");
  property p_hole;
    rd_addr_in == 9'h185 || rd_addr_in == 9'h189 |-> rd_data_out == 8'h00;
  endproperty
  a_hole: assert property (p_hole) else $error("hole reads nonzero");
  c_clr: cover property (core_wr_in.wr && core_wr_in.clr);
  c_sleep: cover property (sleep_instr_in);
  c_ind: cover property (indirect_wr_out);
endmodule
`default_nettype wire

// ### data_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// Unwritten words hold a pattern, so a stale or wrong address shows up.
module data_mem_model (
  input  wire logic       mclk_in,
  input  wire logic [8:0] addr_in,
  input  wire logic       wr_in,
  input  wire logic [7:0] wdata_in,
  output logic      [7:0] rdata_out
);
  logic [7:0] mem [0:511];
  initial for (int i = 0; i < 512; i++) mem[i] = i[7:0] ^ 8'h5a;
  always @(posedge mclk_in) if (wr_in) mem[addr_in] <= wdata_in;
  assign rdata_out = mem[addr_in];
endmodule
`default_nettype wire

// ### tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam logic [8:0] ST = bank3_sfr_pkg::ADDR_STATUS;
  logic                    mclk_in = 0;
  logic                    rstn_in = 0;
  bank3_sfr_pkg::core_wr_t cw      = '0;
  logic [6:0]              af      = '0;
  logic [2:0]              ev      = '0;
  logic [8:0]              ra      = '0;
  int                      n_errors = 0;
  int                      compares = 0;
  int                      cyc      = 0;
  wire logic [7:0]         rd, mrd, iwd;
  wire logic [8:0]         ia;
  wire logic               iw;
  wire logic [1:0]         db;
  wire logic [7:0]         sf, oc, pb, pf, pg, ic, pl, dl, al;
  wire logic [5:0]         dh;
  wire logic [4:0]         ph, ah;
  logic [8:0] adr [0:13] = '{9'h181, 9'h182, 9'h183, 9'h184, 9'h186, 9'h187, 9'h188,
                             9'h18a, 9'h18b, 9'h18c, 9'h18d, 9'h18e, 9'h18f, 9'h185};
  logic [7:0] rv [0:13] = '{8'hff, 8'h00, 8'h18, 8'h00, 8'hff, 8'hff, 8'hff, 8'h00, 8'h00,
                            8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] wv [0:13] = '{8'ha5, 8'ha5, 8'h18, 8'ha5, 8'ha5, 8'ha5, 8'ha5,
                            8'h05, 8'ha5, 8'ha5, 8'ha5, 8'h25, 8'h05, 8'h00};
  bank3_sfr_and_status_flags u_dut (
    .mclk_in, .rstn_in, .core_wr_in(cw), .rd_addr_in(ra), .rd_data_out(rd),
    .alu_flags_in(af), .watchdog_clear_instr_in(ev[2]), .sleep_instr_in(ev[1]),
    .watchdog_timeout_in(ev[0]), .indirect_addr_out(ia), .indirect_wr_out(iw),
    .indirect_wdata_out(iwd), .indirect_rdata_in(mrd), .direct_bank_out(db),
    .status_flags_out(sf), .option_config_out(oc), .port_b_direction_out(pb),
    .port_f_direction_out(pf), .port_g_direction_out(pg), .interrupt_control_out(ic),
    .program_counter_low_out(pl), .program_counter_high_latch_out(ph),
    .progmem_data_low_out(dl), .progmem_address_low_out(al), .progmem_data_high_out(dh),
    .progmem_address_high_out(ah));
  data_mem_model u_mem (.mclk_in, .addr_in(ia), .wr_in(iw), .wdata_in(iwd), .rdata_out(mrd));
  always #2.5 mclk_in = ~mclk_in;
  task automatic results;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic cmp(input logic [8:0] g, input logic [8:0] e);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("Error %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk(input logic [8:0] a, input logic [7:0] e);
    ra = a;
    #1;
    cmp({1'b0, rd}, {1'b0, e});
  endtask
  // One core cycle: a write, ALU strobes and event pulses, all held for one edge.
  task automatic wr(input logic [8:0] a, input logic [7:0] d, input logic c,
                    input logic [6:0] f, input logic [2:0] v);
    @(posedge mclk_in);
    #1;
    cw = '{1'b1, c, a, d};
    af = f;
    ev = v;
    @(posedge mclk_in);
    #1;
    cw = '0;
    af = '0;
    ev = '0;
  endtask
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 2000) begin
      n_errors++;
      $display("Error %0t: timeout", $time);
      results;
    end
  end
  initial begin
    repeat (2) @(posedge mclk_in);
    #1;
    rstn_in = 1;
    for (int i = 0; i < 14; i++) chk(adr[i], rv[i]);
    for (int i = 0; i < 14; i++) if (i != 2) wr(adr[i], 8'ha5, 0, 0, 0);
    for (int i = 0; i < 14; i++) chk(adr[i], wv[i]);
    cmp({1'b0, oc}, 9'h0a5);
    cmp({1'b0, pl}, 9'h0a5);
    cmp({1'b0, pb}, 9'h0a5);
    cmp({1'b0, pf}, 9'h0a5);
    cmp({1'b0, pg}, 9'h0a5);
    cmp({1'b0, ic}, 9'h0a5);
    cmp({1'b0, dl}, 9'h0a5);
    cmp({1'b0, al}, 9'h0a5);
    cmp({4'h0, ph}, 9'h005);
    cmp({3'h0, dh}, 9'h025);
    cmp({4'h0, ah}, 9'h005);
    cmp({1'b0, sf}, 9'h018);
    wr(ST, 8'h00, 0, 0, 0);
    chk(ST, 8'h18);
    wr(ST, 8'he7, 0, 0, 0);
    chk(ST, 8'hff);
    cmp({7'h0, db}, 9'h003);
    wr(9'h185, 0, 0, 0, 3'b010);
    chk(ST, 8'hf7);
    wr(ST, 8'h00, 0, 0, 0);
    chk(ST, 8'h10);
    wr(9'h185, 0, 0, 0, 3'b001);
    chk(ST, 8'h00);
    wr(9'h185, 0, 0, 0, 3'b100);
    chk(ST, 8'h18);
    wr(ST, 8'h07, 0, 7'b1110001, 0);
    chk(ST, 8'h19);
    wr(9'h185, 0, 0, 7'b1111011, 0);
    chk(ST, 8'h1b);
    wr(ST, 8'he2, 0, 0, 0);
    chk(ST, 8'hfa);
    wr(ST, 8'h00, 1, 7'b0000000, 0);
    chk(ST, 8'h1e);
    wr(ST, 8'h80, 0, 0, 0);
    wr(9'h184, 8'h42, 0, 0, 0);
    cmp(ia, 9'h142);
    wr(9'h180, 8'h3c, 0, 0, 0);
    chk(9'h180, 8'h3c);
    @(posedge mclk_in);
    #1;
    rstn_in = 0;
    @(posedge mclk_in);
    #1;
    rstn_in = 1;
    for (int i = 0; i < 14; i++) chk(adr[i], rv[i]);
    results;
  end
endmodule
bind bank3_sfr_and_status_flags bank3_sfr_checker u_chk (.mclk_in, .rstn_in, .core_wr_in,
  .rd_addr_in, .rd_data_out, .alu_flags_in, .watchdog_clear_instr_in, .sleep_instr_in,
  .watchdog_timeout_in, .indirect_addr_out, .indirect_wr_out, .indirect_rdata_in,
  .direct_bank_out, .status_flags_out);
`default_nettype wire
